/* File: common/tuch_pkg.sv */
// Shared constants and pin bundles for the tape unit command controller
package tuch_pkg;
  // Register byte offsets
  localparam logic [3:0] TUCH_CTRL_OFF = 4'h0;
  localparam logic [3:0] TUCH_CMD_OFF = 4'h4;
  localparam logic [3:0] TUCH_WDATA_OFF = 4'h8;
  localparam logic [3:0] TUCH_STAT_OFF = 4'hC;
  // Control register field positions
  localparam int TUCH_CTRL_SELECT = 0;
  localparam int TUCH_CTRL_GO = 1;
  localparam int TUCH_CTRL_SIMUL = 2;
  localparam int TUCH_CTRL_COMPAT = 3;
  localparam int TUCH_CTRL_LRCC = 4;
  localparam logic [4:0] TUCH_CTRL_RST = 5'h00;
  // Write data register: bits 8:0 bus, bit 9 fires a write pulse
  localparam int TUCH_WD_FIRE = 9;
  localparam logic [8:0] TUCH_WBUS_RST = 9'h000;
  // Minimum write pulse width, in ns, and the clock period
  localparam int TUCH_CLK_NS = 4;
  localparam int TUCH_WP_MIN_NS = 3000;
  localparam int TUCH_WP_CYC = (TUCH_WP_MIN_NS + TUCH_CLK_NS - 1) / TUCH_CLK_NS;
  localparam logic [11:0] TUCH_WP_CNT_RST = 12'h000;

  // Command codes written to the command register
  typedef enum logic [2:0] {
    TUCH_CMD_NONE = 3'b000,
    TUCH_CMD_BACK = 3'b001,
    TUCH_CMD_SET_READ = 3'b010,
    TUCH_CMD_SET_WRITE = 3'b011,
    TUCH_CMD_REWIND = 3'b100,
    TUCH_CMD_REW_UNLOAD = 3'b101,
    TUCH_CMD_SET_NRZI = 3'b110
  } tuch_cmd_t;

  typedef enum logic [0:0] {
    TUCH_ST_IDLE = 1'b0,
    TUCH_ST_HOLD = 1'b1
  } tuch_state_t;

  // Lines driven toward the tape unit
  typedef struct packed {
    logic select;
    logic go;
    logic backward;
    logic set_read;
    logic set_write;
    logic rewind;
    logic rewind_unload;
    logic set_nrzi_lrcc;
    logic write_pulse;
    logic simul_ctrl;
    logic [8:0] write_bus;
  } tuch_out_pins_t;

  // Lines returned by the tape unit
  typedef struct packed {
    logic old_model_id;
    logic not_ready;
    logic tape_start_marker;
    logic read_status;
    logic backward_status;
    logic nrzi;
    logic tape_end_indicator_off;
  } tuch_in_pins_t;
endpackage : tuch_pkg

/* File: rtl/tuch_ctrl.sv */
// Tape unit command controller with a classic Wishbone register slave
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tuch_ctrl
  import tuch_pkg::*;
#(
  parameter int WP_CYCLES = TUCH_WP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire tuch_in_pins_t tape_i,
  output tuch_out_pins_t tape_o
);

  // Synchronised unit status lines
  tuch_in_pins_t sync1_r;
  tuch_in_pins_t stat_r;
  // Software state
  logic [4:0] ctrl_r;
  logic [8:0] wbus_r;
  tuch_cmd_t cmd_r;
  tuch_state_t st_r;
  logic [11:0] wp_cnt_r;
  logic wp_r;
  logic refused_r;
  logic compat_fault_r;
  logic ack_r;
  logic [31:0] rdata_r;

  // Bus decode
  // Writes need byte lane 0, and the fire bit needs lane 1 as well
  wire logic bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic wr_req = bus_req & wb_we_i & wb_sel_i[0];
  wire logic wr_ctrl = wr_req & (wb_adr_i == TUCH_CTRL_OFF);
  wire logic wr_cmd = wr_req & (wb_adr_i == TUCH_CMD_OFF);
  wire logic wr_wd = wr_req & (wb_adr_i == TUCH_WDATA_OFF);
  wire logic fire_req = wr_wd & wb_sel_i[1] & wb_dat_i[TUCH_WD_FIRE];
  wire tuch_cmd_t cmd_req = tuch_cmd_t'(wb_dat_i[2:0]);
  wire logic cmd_take = wr_cmd & (st_r == TUCH_ST_IDLE) &
                        (cmd_req != TUCH_CMD_NONE) &
                        (cmd_req != 3'b111);

  // An older unit with compatibility answers only a Model 2 controller
  wire logic compat_bad = stat_r.old_model_id & ~ctrl_r[TUCH_CTRL_COMPAT];

  // Response that ends the held command
  logic cmd_done;
  always_comb begin
    unique case (cmd_r)
      TUCH_CMD_BACK: cmd_done = stat_r.backward_status;
      TUCH_CMD_SET_READ: cmd_done = stat_r.read_status;
      TUCH_CMD_SET_WRITE: cmd_done = ~stat_r.read_status;
      TUCH_CMD_REWIND: cmd_done = stat_r.not_ready |
                                  stat_r.tape_start_marker;
      TUCH_CMD_REW_UNLOAD: cmd_done = stat_r.not_ready;
      TUCH_CMD_SET_NRZI: cmd_done = stat_r.nrzi;
      default: cmd_done = 1'b1;
    endcase
  end

  // Next state of the command handshake
  wire tuch_state_t st_nxt = (st_r == TUCH_ST_IDLE) ?
      (cmd_take ? TUCH_ST_HOLD : TUCH_ST_IDLE) :
      (cmd_done ? TUCH_ST_IDLE : TUCH_ST_HOLD);
  wire logic holding = (st_r == TUCH_ST_HOLD);

  // Write pulse timer: starts only when idle, never cut short
  wire logic wp_start = fire_req & ~wp_r & ~compat_bad;
  wire logic [11:0] wp_load = 12'(WP_CYCLES - 1);
  wire logic wp_nxt = wp_start | (wp_r & (wp_cnt_r != 12'h000));
  wire logic [11:0] wp_cnt_nxt = wp_start ? wp_load :
      (wp_r && wp_cnt_r != 12'h000) ? 12'(wp_cnt_r - 12'h001) : wp_cnt_r;

  // Read data selection
  // Status word: synced pins, then held, pulse, refused and fault flags
  wire logic [31:0] stat_word = {21'h000000, compat_fault_r, refused_r,
                                 wp_r, holding, stat_r};
  wire logic [31:0] rd_sel =
      (wb_adr_i == TUCH_CTRL_OFF) ? {27'h0000000, ctrl_r} :
      (wb_adr_i == TUCH_CMD_OFF) ? {29'h00000000, cmd_r} :
      (wb_adr_i == TUCH_WDATA_OFF) ? {22'h000000, wp_r, wbus_r} :
      (wb_adr_i == TUCH_STAT_OFF) ? stat_word : 32'h00000000;

  // Two-flop synchroniser on all unit status lines
  // The unit's lines are asynchronous to this clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= '0;
      stat_r <= '0;
    end else if (ce_i) begin
      sync1_r <= tape_i;
      stat_r <= sync1_r;
    end
  end

  // Bus slave: one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else if (ce_i) begin
      ack_r <= bus_req;
      if (bus_req) begin
        rdata_r <= rd_sel;
      end
    end
  end

  // Control and write data registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= TUCH_CTRL_RST;
      wbus_r <= TUCH_WBUS_RST;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_r <= wb_dat_i[4:0];
      end
      if (wr_wd && !wp_r) begin
        wbus_r <= wb_dat_i[8:0]; // Bus frozen while a pulse is out
      end
    end
  end

  // Command handshake and sticky error flags; a new event beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= TUCH_ST_IDLE;
      cmd_r <= TUCH_CMD_NONE;
      refused_r <= 1'b0;
      compat_fault_r <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      if (cmd_take) begin
        cmd_r <= cmd_req;
      end else if (holding && cmd_done) begin
        cmd_r <= TUCH_CMD_NONE;
      end
      if (wr_cmd && !cmd_take) begin
        refused_r <= 1'b1;
      end else if (wr_ctrl && wb_dat_i[31]) begin
        refused_r <= 1'b0;
      end
      if (compat_bad && ctrl_r[TUCH_CTRL_SELECT]) begin
        compat_fault_r <= 1'b1;
      end else if (wr_ctrl && wb_dat_i[30]) begin
        compat_fault_r <= 1'b0;
      end
    end
  end

  // Write pulse timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= 1'b0;
      wp_cnt_r <= TUCH_WP_CNT_RST;
    end else if (ce_i) begin
      wp_r <= wp_nxt;
      wp_cnt_r <= wp_cnt_nxt;
    end
  end

  // Pin drive; go is withheld from a mismatched compatibility unit
  assign tape_o.select = ctrl_r[TUCH_CTRL_SELECT];
  assign tape_o.go = ctrl_r[TUCH_CTRL_GO] & ~compat_bad;
  assign tape_o.backward = holding & (cmd_r == TUCH_CMD_BACK);
  assign tape_o.set_read = holding & (cmd_r == TUCH_CMD_SET_READ);
  assign tape_o.set_write = holding & (cmd_r == TUCH_CMD_SET_WRITE);
  assign tape_o.rewind = holding & (cmd_r == TUCH_CMD_REWIND);
  assign tape_o.rewind_unload = holding & (cmd_r == TUCH_CMD_REW_UNLOAD);
  assign tape_o.set_nrzi_lrcc = (holding & (cmd_r == TUCH_CMD_SET_NRZI)) |
                                ctrl_r[TUCH_CTRL_LRCC];
  assign tape_o.write_pulse = wp_r;
  assign tape_o.simul_ctrl = ctrl_r[TUCH_CTRL_SIMUL];
  assign tape_o.write_bus = wbus_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // Checks
  // Cycles the write pulse has stood so far, cleared between pulses
  logic [11:0] hi_len_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_len_r <= 12'h000;
    end else if (ce_i) begin
      hi_len_r <= wp_r ? 12'(hi_len_r + 12'h001) : 12'h000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pulse_min_width: assert property (
    (ce_i && wp_r && !wp_nxt) |-> (hi_len_r + 12'h001 >= 12'(WP_CYCLES)))
    else $error("write pulse shorter than minimum");
  a_back_hold: assert property (
    (ce_i && tape_o.backward && !stat_r.backward_status) |=>
      (tape_o.backward || !ce_i))
    else $error("backward dropped before backward status");
  a_read_hold: assert property (
    (ce_i && tape_o.set_read && !stat_r.read_status) |=>
      (tape_o.set_read || !ce_i))
    else $error("set read dropped before read status");
  a_write_hold: assert property (
    (ce_i && tape_o.set_write && stat_r.read_status) |=>
      (tape_o.set_write || !ce_i))
    else $error("set write dropped before write status");
  a_rewind_hold: assert property (
    (ce_i && tape_o.rewind && !stat_r.not_ready &&
     !stat_r.tape_start_marker) |=> (tape_o.rewind || !ce_i))
    else $error("rewind dropped before its answer");
  a_rewind_release: assert property (
    (ce_i && tape_o.rewind && stat_r.tape_start_marker) |=> !tape_o.rewind)
    else $error("rewind held after unit answered");
  a_unload_hold: assert property (
    (ce_i && tape_o.rewind_unload && !stat_r.not_ready) |=>
      (tape_o.rewind_unload || !ce_i))
    else $error("rewind unload dropped before not ready");
  a_simul_level: assert property (
    (ce_i && !wr_ctrl) |=> $stable(tape_o.simul_ctrl))
    else $error("simultaneous control changed without a write");
  a_compat_go: assert property (
    (stat_r.old_model_id && !ctrl_r[TUCH_CTRL_COMPAT]) |-> !tape_o.go)
    else $error("go driven to a mismatched compatibility unit");
  a_one_cmd: assert property (
    $onehot0({tape_o.backward, tape_o.set_read, tape_o.set_write,
              tape_o.rewind, tape_o.rewind_unload}))
    else $error("two command lines at once");

  // Each held command ends in the cycle after its answer is seen
  a_back_release: assert property (
    (ce_i && tape_o.backward && stat_r.backward_status) |=> !tape_o.backward)
    else $error("backward held after backward status");
  a_read_release: assert property (
    (ce_i && tape_o.set_read && stat_r.read_status) |=> !tape_o.set_read)
    else $error("set read held after read status");
  a_write_release: assert property (
    (ce_i && tape_o.set_write && !stat_r.read_status) |=>
      !tape_o.set_write)
    else $error("set write held after write status");
  a_unload_release: assert property (
    (ce_i && tape_o.rewind_unload && stat_r.not_ready) |=>
      !tape_o.rewind_unload)
    else $error("rewind unload held after not ready");
  a_nrzi_hold: assert property (
    (ce_i && holding && cmd_r == TUCH_CMD_SET_NRZI && !stat_r.nrzi) |=>
      (tape_o.set_nrzi_lrcc || !ce_i))
    else $error("set nrzi dropped before nrzi indication");
  a_nrzi_release: assert property (
    (ce_i && holding && cmd_r == TUCH_CMD_SET_NRZI && stat_r.nrzi) |=>
      !holding)
    else $error("set nrzi held after nrzi indication");

  // Commands start only when taken, and a refused one is flagged
  a_cmd_start: assert property (
    (ce_i && !holding && !cmd_take) |=> !holding)
    else $error("command line raised without a taken command");
  a_refused_set: assert property (
    (ce_i && wr_cmd && holding) |=> refused_r)
    else $error("command during a held one not flagged");

  // Pulse never overstays, and the write bus stays put under it
  a_pulse_max_width: assert property (
    wp_r |-> (hi_len_r < 12'(WP_CYCLES)))
    else $error("write pulse longer than programmed");
  a_wbus_stable: assert property (
    (ce_i && wp_r) |=> $stable(tape_o.write_bus))
    else $error("write bus changed under a write pulse");

  // A mismatched older unit raises the sticky fault whenever it is selected
  a_compat_fault: assert property (
    (ce_i && compat_bad && tape_o.select) |=> compat_fault_r)
    else $error("compatibility mismatch not flagged");

  c_rewind_done: cover property (tape_o.rewind ##1 !tape_o.rewind);
  c_write_pulse: cover property ($fell(tape_o.write_pulse));
  c_set_write: cover property (tape_o.set_write ##1 !tape_o.set_write);
  c_refused: cover property ($rose(refused_r));
  c_compat_fault: cover property ($rose(compat_fault_r));

endmodule : tuch_ctrl
`default_nettype wire

/* File: bench/tuch_unit_model.sv */
// Behavioural tape unit that answers the controller's command lines
`timescale 1ns/1ps
`default_nettype none
module tuch_unit_model
  import tuch_pkg::*;
(
  input wire logic clk_i,
  input wire logic [3:0] dly_i,
  input wire logic old_id_i,
  input wire tuch_out_pins_t pins_i,
  output tuch_in_pins_t pins_o
);
  tuch_out_pins_t hist_r [16];
  tuch_out_pins_t seen;
  logic rd_r = 1'b0, bw_r = 1'b0, nz_r = 1'b0, lp_r = 1'b0, nr_r = 1'b0;
  logic sel;

  // Delay line lets the unit answer promptly or slowly
  initial begin
    for (int i = 0; i < 16; i++) hist_r[i] = '0;
  end
  always @(posedge clk_i) begin
    hist_r[0] <= pins_i;
    for (int i = 1; i < 16; i++) hist_r[i] <= hist_r[i-1];
  end
  assign seen = hist_r[dly_i];
  assign sel = pins_i.select;

  // Read, backward and load point latches hold until an opposing line; nrzi and not ready never clear
  always @(posedge clk_i) begin
    if (seen.set_read | seen.backward) rd_r <= 1'b1;
    if (seen.set_write) rd_r <= 1'b0;
    if (seen.backward) bw_r <= 1'b1;
    if (seen.set_read | seen.set_write) bw_r <= 1'b0;
    if (seen.set_nrzi_lrcc) nz_r <= 1'b1;
    if (seen.rewind) lp_r <= 1'b1;
    if (seen.go & ~bw_r) lp_r <= 1'b0;
    if (seen.rewind_unload) nr_r <= 1'b1;
  end

  // Identity line active only for an older unit, low for a newer one
  assign pins_o = {sel & old_id_i, nr_r, sel & lp_r, sel & rd_r,
                   bw_r, nz_r, sel};
endmodule : tuch_unit_model
`default_nettype wire

/* File: bench/tuch_ctrl_test.sv */
// Self-checking bench for the tape unit command controller
`timescale 1ns/1ps
`default_nettype none
module tuch_ctrl_test
  import tuch_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, old_id = 1'b0;
  logic [3:0] adr = 4'h0, dly = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  tuch_in_pins_t tape_i;
  tuch_out_pins_t tape_o;
  int n_fail = 0, n_tests = 0, cyc_cnt = 0;

  // Clock of 4 ns
  always #2 clk_i = ~clk_i;

  tuch_ctrl #(.WP_CYCLES(4)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tape_i(tape_i), .tape_o(tape_o));
  tuch_unit_model i_unit (.clk_i(clk_i), .dly_i(dly), .old_id_i(old_id),
    .pins_i(tape_o), .pins_o(tape_i));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Cycles that one pin stays high, from now on
  task automatic width(input int b, output int n);
    n = 0;
    for (int i = 0; i < 300; i++) begin
      if (tape_o[b] === 1'b1) n++;
      else if (n > 0) break;
      @(posedge clk_i);
    end
  endtask : width

  task automatic cmd(input logic [2:0] c, input logic [3:0] d,
                     input logic [6:0] st);
    int n;
    dly <= d;
    wb(1'b1, TUCH_CMD_OFF, {29'h0, c});
    width(17 - c, n);
    // Line stands: unit capture, its delay, latch, two sync flops, release
    check("held cycles", n, {28'h0, d} + 32'h5);
    wb(1'b0, TUCH_STAT_OFF, 32'h0);
    check("status", q[10:0], {4'h0, st});
  endtask : cmd

  task automatic refuse();
    int n;
    dly <= 4'hF;
    wb(1'b1, TUCH_CMD_OFF, 32'h1);
    wb(1'b1, TUCH_CMD_OFF, 32'h2);
    wb(1'b0, TUCH_CMD_OFF, 32'h0);
    check("held code", q, 32'h1);
    wb(1'b0, TUCH_STAT_OFF, 32'h0);
    check("refused", q[9:7], 3'b101);
    width(16, n);
    wb(1'b1, TUCH_CTRL_OFF, 32'h80000005);
    wb(1'b0, TUCH_STAT_OFF, 32'h0);
    check("after backward", q[10:0], 11'h00D);
    wb(1'b1, TUCH_CMD_OFF, 32'h7);
    wb(1'b0, TUCH_STAT_OFF, 32'h0);
    check("code 7 refused", q[9:7], 3'b100);
    wb(1'b1, TUCH_CTRL_OFF, 32'h80000005);
  endtask : refuse

  task automatic pulse();
    int n;
    wb(1'b1, TUCH_WDATA_OFF, 32'h3A5);
    check("write bus", tape_o.write_bus, 9'h1A5);
    width(10, n);
    check("pulse width", n, 4);
  endtask : pulse

  // Clock enable low freezes the pulse timer in mid-pulse
  task automatic freeze();
    int n;
    wb(1'b1, TUCH_WDATA_OFF, 32'h200);
    ce <= 1'b0;
    repeat (5) @(posedge clk_i);
    check("frozen pulse", tape_o.write_pulse, 1'b1);
    ce <= 1'b1;
    width(10, n);
    check("pulse after freeze", n, 4);
  endtask : freeze

  task automatic compat();
    old_id <= 1'b1;
    wb(1'b1, TUCH_CTRL_OFF, 32'h7);
    repeat (4) @(posedge clk_i);
    check("go withheld", tape_o.go, 1'b0);
    wb(1'b0, TUCH_STAT_OFF, 32'h0);
    check("model id", q[6], 1'b1);
    check("compat fault", q[10], 1'b1);
    wb(1'b1, TUCH_CTRL_OFF, 32'hF);
    check("go allowed", tape_o.go, 1'b1);
    check("simul held", tape_o.simul_ctrl, 1'b1);
    wb(1'b1, TUCH_CTRL_OFF, 32'h1F);
    check("lrcc gate", tape_o.set_nrzi_lrcc, 1'b1);
  endtask : compat

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check("pins after reset", tape_o, 19'h0);
    wb(1'b0, TUCH_CTRL_OFF, 32'h0);
    check("ctrl reset", q, 32'h0);
    wb(1'b0, 4'h2, 32'h0);
    check("unmapped read", q, 32'h0);
    wb(1'b1, TUCH_CTRL_OFF, 32'h5);
    cmd(3'h2, 4'h0, 7'h09);
    refuse();
    cmd(3'h3, 4'h6, 7'h01);
    cmd(3'h6, 4'h1, 7'h03);
    cmd(3'h4, 4'h6, 7'h13);
    cmd(3'h5, 4'h2, 7'h33);
    pulse();
    freeze();
    compat();
    stop_test();
  end

  // Watchdog against a hung handshake
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      n_fail++;
      stop_test();
    end
  end
endmodule : tuch_ctrl_test
`default_nettype wire
